// [pkg/ssc_pkg.sv]
// Shared constants for the synthesizer serial-port controller
package ssc_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 20; // System clock period
  localparam int SCK_PERIOD_NS = 160; // Generated shift clock period
  localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS); // Cycles per half
  localparam int SEN_LOW_NS = 20; // Least select low time between frames
  localparam int SEN_LOW_CYC = (SEN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_WAIT_NS = 250000; // Device settles after power-up
  localparam int POR_WAIT_CYC = (POR_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  ////////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam int FRAME_EDGES = 32; // Rising edges per frame
  localparam int ADDR_BITS = 6; // Device address width
  localparam int DATA_BITS = 24; // Device data width
  localparam int FIRST_DATA_EDGE = 8; // First edge carrying data
  localparam int LAST_DATA_EDGE = 31; // Last edge carrying data
  ////////////////////////////////////////////////////////////////////////////
  // Controller register offsets (byte addresses)
  localparam logic [7:0] OFS_CMD = 8'h00; // Launch single frame
  localparam logic [7:0] OFS_WDATA = 8'h04; // Write data of a single frame
  localparam logic [7:0] OFS_RDATA = 8'h08; // Last read data
  localparam logic [7:0] OFS_STATUS = 8'h0C; // Controller state
  localparam logic [7:0] OFS_CTRL = 8'h10; // Chip enable pin
  localparam logic [7:0] OFS_TUNE_INT = 8'h14; // Retune, launches sequence
  localparam logic [7:0] OFS_TUNE_FRAC = 8'h18; // Final fractional value
  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CMD_READ_BIT = 6; // 1 = read frame
  localparam int TUNE_FRAC_MODE_BIT = 16; // 1 = fractional-mode sequence
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LOCK_BIT = 1;
  localparam int ST_POR_BIT = 2;
  localparam int ST_VOID_BIT = 3;
  localparam int INTG_UPPER_LSB = 5; // Upper 11 divider bits start here
  localparam int SWRST_BIT = 0; // Soft reset strobe bit
  ////////////////////////////////////////////////////////////////////////////
  // Reset values and device addresses
  localparam logic CTRL_CE_RESET = 1'b1; // Chip enabled after reset
  localparam logic [15:0] INTG_DEFAULT = 16'h00C8; // Device divider default
  localparam logic [23:0] SEED_NONZERO = 24'h50_894C; // Seed restored after fractional retune
  localparam logic [5:0] DEV_ADDR_ID_RST = 6'h00;
  localparam logic [5:0] DEV_ADDR_INTG = 6'h03;
  localparam logic [5:0] DEV_ADDR_FRAC = 6'h04;
  localparam logic [5:0] DEV_ADDR_SEED = 6'h05;
  ////////////////////////////////////////////////////////////////////////////
  // Frame engine states
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_HIGH, ST_LOW, ST_GAP} ssc_state_e;
endpackage : ssc_pkg

// [verilog/ssc_host.sv]
// Behaviour
// - Fractional retune uses six-write safe sequence
// - Integer retune writes intermediate then final
// - Intermediate is OR of start, final
// - Integer mode needs modulator resets cleared
// - Select high, first bit is direction
// - Six address bits, MSB first
// - Twenty-four write bits, MSB first
// - Drop select on 32nd falling edge
// - Read bits sampled on falling edges
// - Unused outputs: disable pads, static source
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
module ssc_host
#(
  parameter int POR_WAIT = ssc_pkg::POR_WAIT_CYC,
  parameter int SCK_HALF = ssc_pkg::SCK_HALF_CYC
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Device serial port
  output logic port_select_o,
  output logic shift_clk_o,
  output logic serial_in_line_o,
  input wire logic lock_or_read_out_i,
  output logic chip_enable_o
);
  import ssc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam int PW = $clog2(POR_WAIT + 1); // Power-up counter width
  ssc_state_e state_reg; // Frame engine state
  logic [7:0] phase_reg; // Half-period timer
  logic [5:0] edge_reg; // Rising edges given so far
  logic [30:0] tx_reg; // Direction, address, data shifter
  logic [23:0] rx_reg; // Read shifter
  logic f_rd_reg; // Frame is a read
  logic [5:0] f_addr_reg; // Frame address
  logic [23:0] f_data_reg; // Frame write data
  logic [6:0] cmd_reg; // Single-frame command
  logic cmd_pend_reg; // Single frame waiting
  logic [23:0] wdata_reg; // Single-frame write data
  logic [23:0] rdata_reg; // Last read word
  logic ce_reg; // Chip enable pin level
  logic lock_reg; // Lock flag seen outside frames
  logic void_reg; // Last read done in power down
  logic [16:0] tune_int_reg; // Final divider and mode
  logic [23:0] tune_frac_reg; // Final fractional value
  logic seq_on_reg; // Retune sequence running
  logic [2:0] step_reg; // Current sequence step
  logic [15:0] cur_intg_reg; // Divider value the device holds
  logic [PW-1:0] por_reg; // Power-up wait counter
  logic por_done; // Device has settled
  logic lrd_s1, lrd_s2; // Read-out pin synchroniser
  logic acc; // Bus access taken this edge
  logic [31:0] wmask; // Byte lane mask
  logic start; // Frame launch
  logic [15:0] mid_intg; // Intermediate divider
  logic n_rd; // Next frame fields
  logic [5:0] n_addr;
  logic [23:0] n_data;
  logic [7:0] half_m1;

  assign half_m1 = 8'(SCK_HALF - 1);
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign por_done = (por_reg == PW'(POR_WAIT));
  // OR keeps every set upper bit of the start value alive
  assign mid_intg = cur_intg_reg | tune_int_reg[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Next frame selection: sequence steps win over a single command
  always_comb
  begin
    n_rd = 1'b0;
    n_addr = DEV_ADDR_INTG;
    n_data = '0;
    if (seq_on_reg)
    begin
      // Seed and fraction zeroed, divider twice, then seed and fraction
      unique case (step_reg)
        3'h0: n_addr = DEV_ADDR_SEED;
        3'h1: n_addr = DEV_ADDR_FRAC;
        3'h2: n_data = {8'h00, mid_intg};
        3'h3: n_data = {8'h00, tune_int_reg[15:0]};
        3'h4:
        begin
          n_addr = DEV_ADDR_SEED;
          n_data = SEED_NONZERO;
        end
        default:
        begin
          n_addr = DEV_ADDR_FRAC;
          n_data = tune_frac_reg;
        end
      endcase
    end
    else
    begin
      n_rd = cmd_reg[CMD_READ_BIT];
      n_addr = cmd_reg[5:0];
      n_data = wdata_reg;
    end
  end

  // Launch only once the device has come out of power-up
  assign start = (state_reg == ST_IDLE) && por_done && (seq_on_reg || cmd_pend_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Power-up wait; long on purpose, shorten in simulation
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      por_reg <= '0;
    else if (!por_done)
      por_reg <= por_reg + PW'(1);
  end

  // Read-out pin synchroniser
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      lrd_s1 <= 1'b0;
      lrd_s2 <= 1'b0;
    end
    else
    begin
      lrd_s1 <= lock_or_read_out_i;
      lrd_s2 <= lrd_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine: select, shift clock and shifters
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= ST_IDLE;
      phase_reg <= '0;
      edge_reg <= '0;
      tx_reg <= '0;
      rx_reg <= '0;
      f_rd_reg <= 1'b0;
      f_addr_reg <= '0;
      f_data_reg <= '0;
      port_select_o <= 1'b0;
      shift_clk_o <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (start)
          begin
            // Select rises with the direction bit already on the line
            port_select_o <= 1'b1;
            tx_reg <= {n_rd, n_addr, n_data};
            f_rd_reg <= n_rd;
            f_addr_reg <= n_addr;
            f_data_reg <= n_data;
            edge_reg <= '0;
            phase_reg <= half_m1;
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP, ST_LOW:
        begin
          if (phase_reg == '0)
          begin
            shift_clk_o <= 1'b1;
            edge_reg <= edge_reg + 6'h01;
            phase_reg <= half_m1;
            state_reg <= ST_HIGH;
          end
          else
            phase_reg <= phase_reg - 8'h01;
        end
        ST_HIGH:
        begin
          if (phase_reg == '0)
          begin
            shift_clk_o <= 1'b0;
            phase_reg <= 8'(SEN_LOW_CYC - 1);
            // Falling edge: sample read bit that the device put out
            if (f_rd_reg && edge_reg >= 6'(FIRST_DATA_EDGE)
                && edge_reg <= 6'(LAST_DATA_EDGE))
              rx_reg <= {rx_reg[22:0], lrd_s2};
            if (edge_reg == 6'(FRAME_EDGES))
            begin
              port_select_o <= 1'b0;
              state_reg <= ST_GAP;
            end
            else
            begin
              // Next bit goes out on the falling edge, MSB first
              tx_reg <= {tx_reg[29:0], 1'b0};
              phase_reg <= half_m1;
              state_reg <= ST_LOW;
            end
          end
          else
            phase_reg <= phase_reg - 8'h01;
        end
        ST_GAP:
        begin
          // Keep select low long enough before the next frame
          if (phase_reg == '0)
            state_reg <= ST_IDLE;
          else
            phase_reg <= phase_reg - 8'h01;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign serial_in_line_o = port_select_o ? tx_reg[30] : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Frame completion bookkeeping
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      cur_intg_reg <= INTG_DEFAULT;
      rdata_reg <= '0;
      void_reg <= 1'b0;
      lock_reg <= 1'b0;
    end
    else
    begin
      // Lock shares the pin with read data, so only trust it idle
      if (state_reg == ST_IDLE && !port_select_o)
        lock_reg <= lrd_s2;
      if (state_reg == ST_GAP && phase_reg == 8'(SEN_LOW_CYC - 1))
      begin
        if (f_rd_reg)
        begin
          rdata_reg <= rx_reg;
          // Device output is off in power down, so flag the word
          void_reg <= !chip_enable_o;
        end
        // Device loads the divider at once; track what it now holds
        else if (f_addr_reg == DEV_ADDR_INTG)
          cur_intg_reg <= f_data_reg[15:0];
        else if (f_addr_reg == DEV_ADDR_ID_RST && f_data_reg[SWRST_BIT])
          cur_intg_reg <= INTG_DEFAULT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retune sequencer
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      seq_on_reg <= 1'b0;
      step_reg <= '0;
    end
    else if (acc && wb_we_i && wb_adr_i == OFS_TUNE_INT && !seq_on_reg)
    begin
      seq_on_reg <= 1'b1;
      // Integer mode only needs the two divider writes
      step_reg <= wb_dat_i[TUNE_FRAC_MODE_BIT] ? 3'h0 : 3'h2;
    end
    else if (start && seq_on_reg)
    begin
      if (step_reg == 3'h5 || (step_reg == 3'h3 && !tune_int_reg[TUNE_FRAC_MODE_BIT]))
        seq_on_reg <= 1'b0;
      step_reg <= step_reg + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; a command is refused while another one is still pending
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      cmd_reg <= '0;
      cmd_pend_reg <= 1'b0;
      wdata_reg <= '0;
      ce_reg <= CTRL_CE_RESET;
      tune_int_reg <= '0;
      tune_frac_reg <= '0;
    end
    else
    begin
      if (start && !seq_on_reg)
        cmd_pend_reg <= 1'b0;
      if (acc && wb_we_i)
      begin
        unique case (wb_adr_i)
          OFS_CMD:
            if (!cmd_pend_reg && !seq_on_reg)
            begin
              cmd_reg <= wb_dat_i[6:0];
              cmd_pend_reg <= 1'b1;
            end
          OFS_WDATA: wdata_reg <= (wdata_reg & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
          // Pin low puts the device in power down
          OFS_CTRL: if (wb_sel_i[0]) ce_reg <= wb_dat_i[0];
          OFS_TUNE_INT: if (!seq_on_reg) tune_int_reg <= wb_dat_i[16:0];
          OFS_TUNE_FRAC: tune_frac_reg <= wb_dat_i[23:0];
          default: ;
        endcase
      end
    end
  end

  assign chip_enable_o = ce_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= acc;
      if (acc)
      begin
        unique case (wb_adr_i)
          OFS_CMD: wb_dat_o <= {25'h000_0000, cmd_reg};
          OFS_WDATA: wb_dat_o <= {8'h00, wdata_reg};
          OFS_RDATA: wb_dat_o <= {8'h00, rdata_reg};
          OFS_STATUS: wb_dat_o <= {28'h000_0000, void_reg, por_done, lock_reg,
            (state_reg != ST_IDLE) || cmd_pend_reg || seq_on_reg};
          OFS_CTRL: wb_dat_o <= {31'h0000_0000, ce_reg};
          OFS_TUNE_INT: wb_dat_o <= {15'h0000, tune_int_reg};
          OFS_TUNE_FRAC: wb_dat_o <= {8'h00, tune_frac_reg};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [11:0] sen_cnt; // Cycles select has been high
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i || !port_select_o)
      sen_cnt <= '0;
    else
      sen_cnt <= sen_cnt + 12'h001;
  end

  sequence s_frame_open;
    $rose(port_select_o) ##0 !shift_clk_o;
  endsequence
  sequence s_frame_close;
    $fell(port_select_o) ##0 !shift_clk_o;
  endsequence

  a_first_bit_dir: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_frame_open |-> serial_in_line_o == f_rd_reg)
    else $error("Direction bit wrong at frame start");
  a_frame_length: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_frame_close |-> $past(sen_cnt) == 12'(64 * SCK_HALF - 1))
    else $error("Frame length is not 32 clocks");
  a_last_edge_count: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $fell(port_select_o) |-> $past(edge_reg) == 6'(FRAME_EDGES))
    else $error("Select dropped at wrong edge");
  a_data_stable_high: assert property (@(posedge clock_i) disable iff (!nrst_i)
    shift_clk_o && $past(shift_clk_o) |-> $stable(serial_in_line_o))
    else $error("Serial input moved while clock high");
  a_no_frame_por: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !por_done |-> !port_select_o)
    else $error("Frame sent before power-up wait");
  a_gap_after_frame: assert property (@(posedge clock_i) disable iff (!nrst_i)
    s_frame_close |=> !port_select_o)
    else $error("Select low gap too short");
  a_idle_clock_low: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !port_select_o |-> !shift_clk_o)
    else $error("Shift clock moved outside frame");
  a_mid_keeps_bits: assert property (@(posedge clock_i) disable iff (!nrst_i)
    start && seq_on_reg && step_reg == 3'h2 |->
      (n_data[15:INTG_UPPER_LSB] & cur_intg_reg[15:INTG_UPPER_LSB])
        == cur_intg_reg[15:INTG_UPPER_LSB])
    else $error("Intermediate divider drops a set bit");
  a_ack_single: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus answer not a single cycle");
endmodule : ssc_host

// [dv/ssc_dev_model.sv]
`timescale 1ns/1ps
// Behavioural synthesizer serial port, far side of the controller
module ssc_dev_model
#(
  parameter logic [23:0] ID_WORD = 24'h00_A5C3 // Arbitrary identity value
)
(
  // Serial port from the controller
  input wire logic port_select_i,
  input wire logic shift_clk_i,
  input wire logic serial_in_line_i,
  input wire logic chip_enable_i,
  // Shared lock / read data pin
  output logic lock_or_read_out_o
);
  logic [23:0] regs [0:63]; // Register file, divider writes act at once
  logic [29:0] wlog [0:63]; // Committed writes, {addr, data}
  int wcnt; // Entries in the write log
  int misload; // Divider writes that lose every upper set bit
  logic lock_flag; // Lock state set by the bench
  int cnt; // Rising edges in this frame
  logic rd; // Frame direction
  logic [5:0] adr;
  logic [23:0] sh; // Write data shifter
  logic [23:0] rdsh; // Read data snapshot
  logic dq; // Read bit on the pin
  logic pd; // Powered down
  ////////////////////////////////////////////////////////////////////////////
  // Defaults, used at power-up and by the soft reset strobe
  task automatic defaults();
    foreach (regs[i]) regs[i] = 24'h00_0000;
    regs[1] = 24'h00_0001;
    regs[3] = 24'h00_00C8;
  endtask : defaults
  initial
  begin
    defaults();
    wcnt = 0;
    misload = 0;
    lock_flag = 1'b0;
    cnt = 0;
    rd = 1'b0;
    dq = 1'b0;
  end
  // Pin or register owns power down; the register's keep-on bit sits in reg 1 [1]
  assign pd = regs[1][0] ? !chip_enable_i : !regs[1][1];
  ////////////////////////////////////////////////////////////////////////////
  // Frame capture on rising shift clock edges
  always @(posedge port_select_i) cnt = 0;
  always @(posedge shift_clk_i)
  begin
    if (port_select_i)
    begin
      cnt = cnt + 1;
      if (cnt == 1) rd = serial_in_line_i;
      else if (cnt <= 7) adr = {adr[4:0], serial_in_line_i};
      else if (cnt <= 31) sh = {sh[22:0], serial_in_line_i};
      if (cnt == 7) rdsh = (adr == 6'h00) ? ID_WORD : regs[adr];
      // Disabled output wanders so stale data never passes
      if (rd && cnt >= 8 && cnt <= 31) dq = pd ? ~dq : rdsh[31-cnt];
    end
  end
  // Lock flag everywhere except the data bits of a read
  assign lock_or_read_out_o = (port_select_i && rd && cnt >= 8 && cnt <= 31) ? dq
                            : lock_flag;
  ////////////////////////////////////////////////////////////////////////////
  // Commit only whole write frames, also in power down
  always @(negedge port_select_i)
  begin
    if (!rd && cnt >= 31)
    begin
      wlog[wcnt[5:0]] = {adr, sh};
      wcnt = wcnt + 1;
      if (adr == 6'h00)
      begin
        if (sh[0]) defaults();
      end
      else
      begin
        // No upper divider bit stays set across the load: slow mis-load
        if (adr == 6'h03 && (regs[3][15:5] & sh[15:5]) == 11'h000)
          misload = misload + 1;
        regs[adr] = sh;
      end
    end
  end
endmodule : ssc_dev_model

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import ssc_pkg::*;
  localparam int POR = 20; // Short power-up wait for simulation
  logic clock_i = 0, nrst_i = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic ack, psel, sck, serial_in_line, lro, ce;
  int failures = 0, checks_done = 0, cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  ssc_host #(.POR_WAIT(POR)) dut_u (.clock_i(clock_i), .nrst_i(nrst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .port_select_o(psel), .shift_clk_o(sck),
    .serial_in_line_o(serial_in_line), .lock_or_read_out_i(lro), .chip_enable_o(ce));
  ssc_dev_model dev_u (.port_select_i(psel), .shift_clk_i(sck), .serial_in_line_i(serial_in_line),
    .chip_enable_i(ce), .lock_or_read_out_o(lro));
  initial forever #10 clock_i = ~clock_i;
  // Hang guard
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do @(posedge clock_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // Poll busy with a bounded count
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge clock_i);
    do
    begin
      wb(1'b0, OFS_STATUS, 0);
      n++;
    end while (q[ST_BUSY_BIT] !== 1'b0 && n < 3000);
    if (n >= 3000) check(1, 0);
  endtask : wait_idle
  // One device frame through CMD
  task automatic frame(input logic r, input logic [5:0] a, input logic [23:0] d);
    if (!r) wb(1'b1, OFS_WDATA, {8'h00, d});
    wb(1'b1, OFS_CMD, {25'h0, r, a});
    wait_idle();
  endtask : frame
  function automatic logic [15:0] mid_of(input logic [15:0] s, input logic [15:0] f);
    return s | f; // Keeps a set upper bit through both steps
  endfunction : mid_of
  // Retune and compare the write log against the safe sequence
  task automatic retune(input logic fm, input logic [15:0] s, input logic [15:0] f,
                        input logic [23:0] fr);
    logic [29:0] e [0:5];
    int b, k;
    b = dev_u.wcnt;
    e = '{{DEV_ADDR_SEED, 24'h0}, {DEV_ADDR_FRAC, 24'h0}, {DEV_ADDR_INTG, 8'h0, mid_of(s, f)},
          {DEV_ADDR_INTG, 8'h0, f}, {DEV_ADDR_SEED, SEED_NONZERO}, {DEV_ADDR_FRAC, fr}};
    k = fm ? 0 : 2;
    wb(1'b1, OFS_TUNE_FRAC, {8'h0, fr});
    wb(1'b1, OFS_TUNE_INT, {15'h0, fm, f});
    wait_idle();
    check(dev_u.wcnt - b, fm ? 6 : 2);
    for (int i = k; i < (fm ? 4 : 4) + (fm ? 2 : 0); i++)
      check(dev_u.wlog[(b + i - k) % 64], e[i]);
  endtask : retune
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [5:0] a;
    logic [23:0] d;
    logic [15:0] f;
    void'($urandom(32'h5e7b9249));
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    // Reset state and power-up wait
    wb(1'b0, OFS_STATUS, 0);
    check(q[ST_POR_BIT], 0);
    check(psel, 0);
    wb(1'b0, OFS_CTRL, 0);
    check(q[0], CTRL_CE_RESET);
    // Commands wait for power-up; a second one meanwhile is refused
    wb(1'b1, OFS_WDATA, 32'h0012_3456);
    wb(1'b1, OFS_CMD, 32'h0000_0006);
    wb(1'b1, OFS_CMD, 32'h0000_0007);
    check(psel, 0);
    repeat (POR + 5) @(posedge clock_i);
    wb(1'b0, OFS_STATUS, 0);
    check(q[ST_POR_BIT], 1);
    wait_idle();
    check(dev_u.regs[6], 24'h12_3456);
    check(dev_u.regs[7], 24'h00_0000);
    $display("test reset done");
    // Random writes; a second launch while the first runs is queued
    for (int i = 0; i < 6; i++)
    begin
      a = 6'(6 + $urandom % 58);
      d = 24'($urandom);
      wb(1'b1, OFS_WDATA, {8'h0, d});
      wb(1'b1, OFS_CMD, {26'h0, a});
      if (i == 0) wb(1'b1, OFS_CMD, {26'h0, a ^ 6'h01});
      wait_idle();
      check(dev_u.regs[a], d);
      if (i == 0) check(dev_u.regs[a ^ 6'h01], d);
      frame(1'b1, a, 0);
      wb(1'b0, OFS_RDATA, 0);
      check(q[23:0], d);
    end
    frame(1'b1, DEV_ADDR_ID_RST, 0);
    wb(1'b0, OFS_RDATA, 0);
    check(q[23:0], 24'h00_A5C3);
    $display("test frames done");
    // Lock flag seen outside frames, both levels
    for (int v = 0; v < 2; v++)
    begin
      dev_u.lock_flag <= v[0];
      repeat (6) @(posedge clock_i);
      wb(1'b0, OFS_STATUS, 0);
      check(q[ST_LOCK_BIT], v[0]);
    end
    $display("test lock done");
    // Integer then fractional retune, then soft reset and retune again
    f = 16'($urandom) | 16'h0020; // Device divider is at least 32
    retune(1'b0, INTG_DEFAULT, f, 24'h0);
    retune(1'b1, f, 16'($urandom) | 16'h0400, 24'($urandom));
    frame(1'b0, DEV_ADDR_ID_RST, 24'h00_0001);
    check(dev_u.regs[DEV_ADDR_INTG], {8'h0, INTG_DEFAULT});
    retune(1'b0, INTG_DEFAULT, 16'h0800, 24'h0);
    check(dev_u.regs[DEV_ADDR_INTG], 24'h00_0800);
    check(dev_u.misload, 0);
    $display("test retune done");
    // Power down: writes land, reads are flagged void
    wb(1'b1, OFS_CTRL, 32'h0);
    @(posedge clock_i);
    check(ce, 0);
    d = 24'($urandom);
    frame(1'b0, 6'h07, d);
    check(dev_u.regs[7], d);
    frame(1'b1, 6'h07, 0);
    wb(1'b0, OFS_STATUS, 0);
    check(q[ST_VOID_BIT], 1);
    wb(1'b1, OFS_CTRL, 32'h1);
    frame(1'b1, 6'h07, 0);
    wb(1'b0, OFS_STATUS, 0);
    check(q[ST_VOID_BIT], 0);
    wb(1'b0, OFS_RDATA, 0);
    check(q[23:0], d);
    // Unmapped place reads zero
    wb(1'b1, 8'hFC, $urandom);
    wb(1'b0, 8'hFC, 0);
    check(q, 0);
    $display("test power down done");
    finish_test();
  end
endmodule : tb_top
